// *** pkg/tach_pos_pkg.sv ***
// constants and types shared by the position counter and its pulse decoder
// assumes a single 10 MHz clock and a plain strobe register port
package tach_pos_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PPF = 5'h04;
  localparam logic [4:0] OFS_FREE = 5'h08;
  localparam logic [4:0] OFS_START = 5'h0c;
  localparam logic [4:0] OFS_CMD = 5'h10;
  localparam logic [4:0] OFS_POS = 5'h14;
  localparam logic [4:0] OFS_STAT = 5'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_REF_LSB = 0;
  localparam int CTRL_SENSE_LSB = 2;
  localparam int CTRL_FPS_LSB = 4;
  localparam int CMD_LOAD_BIT = 0;
  localparam int CMD_TRIM_UP_BIT = 1;
  localparam int CMD_TRIM_DN_BIT = 2;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] REF_LTC = 2'h0;
  localparam logic [1:0] REF_VITC = 2'h1;
  localparam logic [1:0] REF_AUTO = 2'h2;
  localparam logic [1:0] REF_BIPH = 2'h3;
  localparam logic [1:0] SNS_A_LEADS = 2'h0;
  localparam logic [1:0] SNS_B_LEADS = 2'h1;
  localparam logic [1:0] SNS_TACH_FWD_LINE_LOW = 2'h2;
  localparam logic [1:0] SNS_TACH_FWD_LINE_HIGH = 2'h3;
  localparam logic [1:0] FPS_24 = 2'h0;
  localparam logic [1:0] FPS_25 = 2'h1;

  // ----------------------------------------
  // limits and reset values
  // ----------------------------------------
  localparam logic [4:0] FR_MAX_24 = 5'h17;
  localparam logic [4:0] FR_MAX_25 = 5'h18;
  localparam logic [4:0] FR_MAX_30 = 5'h1d;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HR_MAX = 5'h17;
  localparam logic [7:0] PPF_MIN = 8'h02;
  localparam logic [7:0] PPF_RST = 8'h02;
  localparam logic [5:0] FREE_MIN = 6'h04;
  localparam logic [5:0] FREE_MAX = 6'h28;
  localparam logic [5:0] FREE_RST = 6'h08;

  typedef struct packed {
    logic [4:0] hr;
    logic [5:0] mn;
    logic [5:0] sc;
    logic [4:0] fr;
  } tc_t;

  typedef enum logic {SEL_LTC, SEL_VITC} sel_t;

endpackage

// *** rtl/biphase_tach_position_counter.sv ***
// position reference logic: reader auto select and pulse-derived address
// assumes reader inputs and encoder pins are synchronous to CLOCK
module biphase_tach_position_counter (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic PULSE_A,
  input wire logic PULSE_B,
  input wire tach_pos_pkg::tc_t LTC_TC,
  input wire logic LTC_OK,
  input wire tach_pos_pkg::tc_t VITC_TC,
  input wire logic VITC_OK,
  input wire logic HIGH_SPEED,
  input wire logic FRAME_TICK,
  output tach_pos_pkg::tc_t TC_ADDR,
  output logic TC_VALID,
  output logic LED_LTC,
  output logic LED_VITC,
  output logic LED_BIPH,
  output logic DP_MIN_SEC,
  output logic READ_SEL_VITC
);
  import tach_pos_pkg::*;

  typedef struct packed {
    logic [1:0] ref_mode;
    logic [1:0] sense;
    logic [1:0] fps;
    logic [7:0] pulses_per_frame;
    logic [5:0] dropout_hold_length;
    tc_t start;
    tc_t pos;
    logic [7:0] sub;
    sel_t sel;
    logic [5:0] fw_cnt;
    logic pos_valid;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic step;
  logic fwd;
  logic wr_ctrl;
  logic wr_cmd;
  logic load_req;
  logic trim_up;
  logic trim_dn;
  logic use_ltc;
  logic use_vitc;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] frame_max(input logic [1:0] fps);
    unique case (fps)
      FPS_24: frame_max = FR_MAX_24;
      FPS_25: frame_max = FR_MAX_25;
      default: frame_max = FR_MAX_30;
    endcase
  endfunction

  // one frame forward or back with carries through hours, wrapping at a day
  function automatic tc_t tc_step(input tc_t t, input logic up, input logic [1:0] fps);
    tc_t r;
    logic [4:0] fmax;
    r = t;
    fmax = frame_max(fps);
    if (up)
    begin
      if (t.fr < fmax)
        r.fr = t.fr + 5'h01;
      else
      begin
        r.fr = '0;
        if (t.sc < SEC_MAX)
          r.sc = t.sc + 6'h01;
        else
        begin
          r.sc = '0;
          if (t.mn < MIN_MAX)
            r.mn = t.mn + 6'h01;
          else
          begin
            r.mn = '0;
            r.hr = (t.hr < HR_MAX) ? t.hr + 5'h01 : 5'h00;
          end
        end
      end
    end
    else
    begin
      if (t.fr != '0)
        r.fr = t.fr - 5'h01;
      else
      begin
        r.fr = fmax;
        if (t.sc != '0)
          r.sc = t.sc - 6'h01;
        else
        begin
          r.sc = SEC_MAX;
          if (t.mn != '0)
            r.mn = t.mn - 6'h01;
          else
          begin
            r.mn = MIN_MAX;
            r.hr = (t.hr != '0) ? t.hr - 5'h01 : HR_MAX;
          end
        end
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // pulse decoding
  // ----------------------------------------
  pulse_direction_decoder u_dec (
    .clock(CLOCK),
    .rst_n(RST_N),
    .line_a(PULSE_A),
    .line_b(PULSE_B),
    .sense(s_r.sense),
    .step(step),
    .fwd(fwd)
  );

  // command strobes are write-only pulses, never stored
  assign wr_ctrl = WR && ADDR == OFS_CTRL;
  assign wr_cmd = WR && ADDR == OFS_CMD;
  assign load_req = wr_cmd && WDATA[CMD_LOAD_BIT];
  assign trim_up = wr_cmd && WDATA[CMD_TRIM_UP_BIT];
  assign trim_dn = wr_cmd && WDATA[CMD_TRIM_DN_BIT];

  // in auto a reader counts as usable only in the speed band where it can be read; in the other modes its ok flag alone decides
  assign use_ltc = LTC_OK && (s_r.ref_mode != REF_AUTO || HIGH_SPEED);
  assign use_vitc = VITC_OK && (s_r.ref_mode != REF_AUTO || !HIGH_SPEED);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    tc_t t;
    logic [7:0] ppf_w;
    logic [5:0] fl_w;
    t = s_r.pos;
    ppf_w = WDATA[7:0];
    fl_w = WDATA[5:0];
    s_nxt = s_r;
    s_nxt.rdata = '0;

    // register writes; out-of-range ppf and hold lengths are clamped, not refused; start is stored as written
    if (wr_ctrl)
    begin
      s_nxt.ref_mode = WDATA[CTRL_REF_LSB +: 2];
      s_nxt.sense = WDATA[CTRL_SENSE_LSB +: 2];
      s_nxt.fps = WDATA[CTRL_FPS_LSB +: 2];
    end
    if (WR && ADDR == OFS_PPF)
      s_nxt.pulses_per_frame = (ppf_w < PPF_MIN) ? PPF_MIN : ppf_w;
    if (WR && ADDR == OFS_FREE)
      s_nxt.dropout_hold_length = (fl_w < FREE_MIN) ? FREE_MIN : (fl_w > FREE_MAX) ? FREE_MAX : fl_w;
    if (WR && ADDR == OFS_START)
      s_nxt.start = WDATA[21:0];

    // position source
    if (s_r.ref_mode == REF_BIPH)
    begin
      // sub-frame accumulation; the sub count is kept below ppf at all times
      if (step)
      begin
        if (fwd)
        begin
          if (s_r.sub >= s_r.pulses_per_frame - 8'h01)
          begin
            s_nxt.sub = '0;
            t = tc_step(t, 1'b1, s_r.fps);
          end
          else
            s_nxt.sub = s_r.sub + 8'h01;
        end
        else if (s_r.sub == '0)
        begin
          s_nxt.sub = s_r.pulses_per_frame - 8'h01;
          t = tc_step(t, 1'b0, s_r.fps);
        end
        else
          s_nxt.sub = s_r.sub - 8'h01;
      end
      if (trim_up && !trim_dn)
        t = tc_step(t, 1'b1, s_r.fps);
      if (trim_dn && !trim_up)
        t = tc_step(t, 1'b0, s_r.fps);
      s_nxt.pos = t;
      s_nxt.pos_valid = 1'b1;
      s_nxt.fw_cnt = '0;
    end
    else
    begin
      // auto: hold the last choice when neither reader is usable
      if (s_r.ref_mode == REF_AUTO)
      begin
        if (use_ltc)
          s_nxt.sel = SEL_LTC;
        else if (use_vitc)
          s_nxt.sel = SEL_VITC;
      end
      else
        s_nxt.sel = (s_r.ref_mode == REF_VITC) ? SEL_VITC : SEL_LTC;
      if (s_nxt.sel == SEL_LTC ? use_ltc : use_vitc)
      begin
        s_nxt.pos = (s_nxt.sel == SEL_LTC) ? LTC_TC : VITC_TC;
        s_nxt.pos_valid = 1'b1;
        s_nxt.fw_cnt = '0;
      end
      else if (FRAME_TICK && s_r.pos_valid)
      begin
        // freewheel: keep counting until the hold length runs out
        if (s_r.fw_cnt < s_r.dropout_hold_length)
        begin
          s_nxt.pos = tc_step(s_r.pos, 1'b1, s_r.fps);
          s_nxt.fw_cnt = s_r.fw_cnt + 6'h01;
        end
        else
          s_nxt.pos_valid = 1'b0;
      end
    end

    // a new ppf restarts the sub-frame count so it never sits above the new limit
    if (WR && ADDR == OFS_PPF)
      s_nxt.sub = '0;
    // load last so it wins over a pulse in the same cycle
    if ((load_req && s_r.ref_mode == REF_BIPH) ||
        (s_nxt.ref_mode == REF_BIPH && s_r.ref_mode != REF_BIPH))
    begin
      s_nxt.pos = s_nxt.start;
      s_nxt.sub = '0;
      s_nxt.pos_valid = 1'b1;
    end

    // read data valid in the cycle after the strobe only
    if (RD)
    begin
      unique case (ADDR)
        OFS_CTRL: s_nxt.rdata = {26'h0, s_r.fps, s_r.sense, s_r.ref_mode};
        OFS_PPF: s_nxt.rdata = {24'h0, s_r.pulses_per_frame};
        OFS_FREE: s_nxt.rdata = {26'h0, s_r.dropout_hold_length};
        OFS_START: s_nxt.rdata = {10'h0, s_r.start};
        OFS_POS: s_nxt.rdata = {10'h0, s_r.pos};
        OFS_STAT: s_nxt.rdata = {16'h0, s_r.sel, s_r.pos_valid, s_r.fw_cnt, s_r.sub};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_r <= '0;
      s_r.pulses_per_frame <= PPF_RST;
      s_r.dropout_hold_length <= FREE_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RDATA = s_r.rdata;
  assign TC_ADDR = s_r.pos;
  assign TC_VALID = s_r.pos_valid;
  assign LED_LTC = s_r.ref_mode == REF_LTC || s_r.ref_mode == REF_AUTO;
  assign LED_VITC = s_r.ref_mode == REF_VITC || s_r.ref_mode == REF_AUTO;
  assign LED_BIPH = s_r.ref_mode == REF_BIPH;
  assign DP_MIN_SEC = s_r.ref_mode == REF_AUTO;
  assign READ_SEL_VITC = s_r.sel == SEL_VITC;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_quiet_biph;
    s_r.ref_mode == REF_BIPH && !wr_ctrl && !load_req;
  endsequence

  property p_auto_ind;
    @(posedge CLOCK) disable iff (!RST_N)
    s_r.ref_mode == REF_AUTO |-> LED_LTC && LED_VITC && DP_MIN_SEC && !LED_BIPH;
  endproperty
  a_auto_ind: assert property (p_auto_ind) else $error("auto indicators wrong");

  property p_auto_fast;
    @(posedge CLOCK) disable iff (!RST_N)
    s_r.ref_mode == REF_AUTO && !wr_ctrl && HIGH_SPEED && LTC_OK
      |=> !READ_SEL_VITC && TC_ADDR == $past(LTC_TC);
  endproperty
  a_auto_fast: assert property (p_auto_fast) else $error("auto did not take ltc at speed");

  property p_auto_slow;
    @(posedge CLOCK) disable iff (!RST_N)
    s_r.ref_mode == REF_AUTO && !wr_ctrl && !HIGH_SPEED && VITC_OK
      |=> READ_SEL_VITC && TC_ADDR == $past(VITC_TC);
  endproperty
  a_auto_slow: assert property (p_auto_slow) else $error("auto did not take vitc when slow");

  property p_load;
    @(posedge CLOCK) disable iff (!RST_N)
    s_r.ref_mode == REF_BIPH && load_req && !(WR && ADDR == OFS_START)
      |=> TC_ADDR == $past(s_r.start) && s_r.sub == '0;
  endproperty
  a_load: assert property (p_load) else $error("start frame not loaded");

  property p_enter_biph;
    @(posedge CLOCK) disable iff (!RST_N)
    wr_ctrl && WDATA[CTRL_REF_LSB +: 2] == REF_BIPH && s_r.ref_mode != REF_BIPH
      |=> LED_BIPH && TC_ADDR == $past(s_r.start) ##1 TC_VALID;
  endproperty
  a_enter_biph: assert property (p_enter_biph) else $error("pulse mode not started at preset");

  property p_trim;
    @(posedge CLOCK) disable iff (!RST_N)
    s_quiet_biph ##0 (!step && trim_up && !trim_dn)
      |=> TC_ADDR == tc_step($past(TC_ADDR), 1'b1, s_r.fps);
  endproperty
  a_trim: assert property (p_trim) else $error("trim up not one frame");

  property p_carry;
    @(posedge CLOCK) disable iff (!RST_N)
    s_quiet_biph ##0 (step && fwd && !trim_up && !trim_dn && s_r.sub == s_r.pulses_per_frame - 8'h01)
      |=> s_r.sub == '0 && TC_ADDR == tc_step($past(TC_ADDR), 1'b1, s_r.fps);
  endproperty
  a_carry: assert property (p_carry) else $error("sub-frame carry wrong");

  property p_ppf_floor;
    @(posedge CLOCK) disable iff (!RST_N)
    WR && ADDR == OFS_PPF |=> s_r.pulses_per_frame >= PPF_MIN && s_r.sub < s_r.pulses_per_frame;
  endproperty
  a_ppf_floor: assert property (p_ppf_floor) else $error("ppf below floor");

  property p_freewheel;
    @(posedge CLOCK) disable iff (!RST_N)
    s_r.ref_mode == REF_LTC && !wr_ctrl && !LTC_OK && FRAME_TICK && TC_VALID
      && s_r.fw_cnt >= s_r.dropout_hold_length |=> !TC_VALID && $stable(TC_ADDR);
  endproperty
  a_freewheel: assert property (p_freewheel) else $error("freewheel ran past its length");

endmodule

// *** rtl/pulse_direction_decoder.sv ***
// turns the two encoder lines into a one-cycle step and a direction
// assumes encoder lines already synchronous to the clock
module pulse_direction_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic line_a,
  input wire logic line_b,
  input wire logic [1:0] sense,
  output logic step,
  output logic fwd
);
  import tach_pos_pkg::*;

  typedef struct packed {
    logic a_q;
    logic step;
    logic fwd;
  } dec_t;

  dec_t s_r;
  dec_t s_nxt;
  logic rise_a;

  assign rise_a = line_a && !s_r.a_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // one count per rising edge of line a; line b level at that edge gives
  // phase order (quadrature) or direction level (tach)
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.a_q = line_a;
    s_nxt.step = rise_a;
    unique case (sense)
      SNS_A_LEADS: s_nxt.fwd = !line_b;
      SNS_B_LEADS: s_nxt.fwd = line_b;
      SNS_TACH_FWD_LINE_LOW: s_nxt.fwd = !line_b;
      SNS_TACH_FWD_LINE_HIGH: s_nxt.fwd = line_b;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign step = s_r.step;
  assign fwd = s_r.fwd;

  property p_quad_order;
    @(posedge clock) disable iff (!rst_n)
    rise_a && (sense == SNS_A_LEADS || sense == SNS_B_LEADS)
      |=> step && (fwd == ($past(sense) == SNS_A_LEADS ? !$past(line_b) : $past(line_b)));
  endproperty
  a_quad_order: assert property (p_quad_order) else $error("quadrature direction wrong");

  property p_tach_level;
    @(posedge clock) disable iff (!rst_n)
    rise_a && sense == SNS_TACH_FWD_LINE_HIGH |=> step && fwd == $past(line_b);
  endproperty
  a_tach_level: assert property (p_tach_level) else $error("tach direction wrong");

endmodule

// *** tb/biphase_tach_position_counter_test.sv ***
// self-checking bench for the pulse-derived position counter
// assumes encoder_model on the pulse lines and a 10 MHz clock
module biphase_tach_position_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tach_pos_pkg::*;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic line_a;
  logic line_b;
  tc_t ltc_tc = '0;
  tc_t vitc_tc = '0;
  logic ltc_ok = 1'b0;
  logic vitc_ok = 1'b0;
  logic high_speed = 1'b0;
  logic frame_tick = 1'b0;
  tc_t tc_addr;
  logic tc_valid;
  logic led_ltc;
  logic led_vitc;
  logic led_biph;
  logic dp;
  logic sel;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 82773;
  int cycles = 0;
  int p;
  logic [31:0] d;
  logic h;
  logic l;
  logic v;
  logic esel;
  logic [4:0] fm;
  tc_t s;
  tc_t e;
  tc_t lt;
  tc_t vt;

  always #50 clock = ~clock;

  biphase_tach_position_counter dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .PULSE_A(line_a), .PULSE_B(line_b), .LTC_TC(ltc_tc), .LTC_OK(ltc_ok),
    .VITC_TC(vitc_tc), .VITC_OK(vitc_ok), .HIGH_SPEED(high_speed), .FRAME_TICK(frame_tick), .TC_ADDR(tc_addr),
    .TC_VALID(tc_valid), .LED_LTC(led_ltc), .LED_VITC(led_vitc), .LED_BIPH(led_biph), .DP_MIN_SEC(dp),
    .READ_SEL_VITC(sel));

  encoder_model enc (.clock(clock), .line_a(line_a), .line_b(line_b));

  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  // one frame forward, fm is the last frame number of the rate; reverse is checked by returning to a known address
  function automatic tc_t nxt(input tc_t t, input logic [4:0] fm);
    tc_t r;
    r = t;
    r.fr = (t.fr == fm) ? 5'h00 : t.fr + 5'h01;
    if (t.fr == fm)
    begin
      r.sc = (t.sc == SEC_MAX) ? 6'h00 : t.sc + 6'h01;
      if (t.sc == SEC_MAX)
      begin
        r.mn = (t.mn == MIN_MAX) ? 6'h00 : t.mn + 6'h01;
        if (t.mn == MIN_MAX)
          r.hr = (t.hr == HR_MAX) ? 5'h00 : t.hr + 5'h01;
      end
    end
    return r;
  endfunction

  function automatic tc_t rtc();
    tc_t r;
    r.hr = 5'($unsigned($random(seed)) % 24);
    r.mn = 6'($unsigned($random(seed)) % 60);
    r.sc = 6'($unsigned($random(seed)) % 60);
    r.fr = 5'($unsigned($random(seed)) % 24);
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] val);
    @(posedge clock);
    addr <= a;
    wdata <= val;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] val);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    val = rdata;
  endtask

  task automatic tick();
    @(posedge clock);
    frame_tick <= 1'b1;
    @(posedge clock);
    frame_tick <= 1'b0;
    @(negedge clock);
  endtask

  // n pulses in the chosen direction for sense k, with random phase lengths
  task automatic mv(input int k, input bit fwd, input int n);
    repeat (n)
      if (k < 2)
        enc.quad(fwd ^ k[0], 1 + $unsigned($random(seed)) % 3);
      else
        enc.tach(fwd ^ (k == 2), 1 + $unsigned($random(seed)) % 3);
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(32'({tc_valid, led_ltc, led_vitc, led_biph, dp, sel}), 32'h10);
    reg_rd(OFS_PPF, d);
    chk(d, 32'h2);
    reg_rd(OFS_FREE, d);
    chk(d, 32'h8);
    reg_rd(5'h1c, d);
    chk(d, 32'h0);
    reg_wr(OFS_PPF, 32'h1);
    reg_rd(OFS_PPF, d);
    chk(d, 32'h2);
    reg_wr(OFS_PPF, 32'hff);
    reg_rd(OFS_PPF, d);
    chk(d, 32'hff);
    reg_wr(OFS_FREE, 32'h2);
    reg_rd(OFS_FREE, d);
    chk(d, 32'h4);
    reg_wr(OFS_FREE, 32'h30);
    reg_rd(OFS_FREE, d);
    chk(d, 32'h28);
    // longitudinal code shown as received, then dropout freewheel of 4 frames
    reg_wr(OFS_FREE, 32'h4);
    s = rtc();
    s.fr = FR_MAX_24 - 5'h01;
    @(posedge clock);
    ltc_tc <= s;
    ltc_ok <= 1'b1;
    high_speed <= 1'b1;
    @(posedge clock);
    ltc_ok <= 1'b0;
    @(negedge clock);
    chk(32'(tc_addr), 32'(s));
    chk(32'(tc_valid), 32'h1);
    e = s;
    repeat (4)
    begin
      tick();
      e = nxt(e, FR_MAX_24);
      chk(32'(tc_addr), 32'(e));
    end
    tick();
    chk(32'(tc_valid), 32'h0);
    // auto select: first two passes are shuttle and parked corners
    reg_wr(OFS_CTRL, 32'(REF_AUTO));
    @(negedge clock);
    chk(32'({led_ltc, led_vitc, led_biph, dp}), 32'hd);
    esel = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      h = (i == 0) || (i > 1 && $random(seed) % 2 != 0);
      l = (i < 2) || ($random(seed) % 2 != 0);
      v = (i == 1) || ($random(seed) % 2 != 0);
      lt = rtc();
      vt = rtc();
      @(posedge clock);
      high_speed <= h;
      ltc_ok <= l;
      vitc_ok <= v;
      ltc_tc <= lt;
      vitc_tc <= vt;
      @(posedge clock);
      @(negedge clock);
      if ((l && h) || (v && !h))
      begin
        esel = !(l && h);
        chk(32'(tc_addr), 32'(esel ? vt : lt));
      end
      chk(32'(sel), 32'(esel));
    end
    // pulse position for every sense and frame rate, across a frame, second, minute and hour carry
    for (int k = 0; k < 4; k++)
    begin
      p = 2 + $unsigned($random(seed)) % 4;
      fm = (k == 0) ? FR_MAX_24 : (k == 1) ? FR_MAX_25 : FR_MAX_30;
      s = rtc();
      s.mn = MIN_MAX;
      s.sc = SEC_MAX;
      s.fr = fm;
      reg_wr(OFS_PPF, 32'(p));
      reg_wr(OFS_START, 32'(s));
      reg_wr(OFS_CTRL, 32'({k[1:0], k[1:0], REF_BIPH}));
      reg_wr(OFS_CMD, 32'h1);
      @(negedge clock);
      chk(32'(tc_addr), 32'(s));
      chk(32'({led_ltc, led_vitc, led_biph, dp}), 32'h2);
      reg_rd(OFS_POS, d);
      chk(d, 32'(s));
      mv(k, 1'b1, p - 1);
      chk(32'(tc_addr), 32'(s));
      reg_rd(OFS_STAT, d);
      chk(32'(d[14:0]), 32'({1'b1, 6'h00, 8'(p - 1)}));
      mv(k, 1'b1, 1);
      chk(32'(tc_addr), 32'(nxt(s, fm)));
      mv(k, 1'b0, p);
      chk(32'(tc_addr), 32'(s));
      reg_wr(OFS_CMD, 32'h2);
      @(negedge clock);
      chk(32'(tc_addr), 32'(nxt(s, fm)));
      reg_wr(OFS_CMD, 32'h4);
      @(negedge clock);
      chk(32'(tc_addr), 32'(s));
    end
    end_of_test();
  end
endmodule

// *** tb/encoder_model.sv ***
// transport encoder model: quadrature or tach pulses on two lines
// assumes the bench calls its tasks from one process, in step with the clock
module encoder_model (
  input wire logic clock,
  output logic line_a,
  output logic line_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // parked transport: both lines stand still low until a move is asked for
  initial
  begin
    line_a = 1'b0;
    line_b = 1'b0;
  end

  // one phase, held for hold cycles so phases can be prompt or slow
  task automatic put(input logic a, input logic b, input int hold);
    @(posedge clock);
    line_a <= a;
    line_b <= b;
    repeat (hold - 1) @(posedge clock);
  endtask

  // one full quadrature cycle; a_first picks which line leads
  task automatic quad(input bit a_first, input int hold);
    if (a_first)
    begin
      put(1'b1, 1'b0, hold);
      put(1'b1, 1'b1, hold);
      put(1'b0, 1'b1, hold);
    end
    else
    begin
      put(1'b0, 1'b1, hold);
      put(1'b1, 1'b1, hold);
      put(1'b1, 1'b0, hold);
    end
    put(1'b0, 1'b0, hold);
  endtask

  // one tach rate pulse; b is the direction level and stays after the pulse
  task automatic tach(input bit b, input int hold);
    put(1'b1, b, hold);
    put(1'b0, b, hold);
  endtask
endmodule
